// ===== verilog/imc_pkg.sv
/*
  package for the interrupt mode control block of sources 48 to 51:
  register offsets, field layout, reset values, mode codes, carriers.
  assumes an APB master with 32-bit data and aligned word access.
*/
// What this block does
// - bit 4 makes source 48 a dma trigger when set, an ordinary interrupt when clear.
// - bit 12 makes source 49 a dma trigger when set, an ordinary interrupt when clear.
// - bit 20 makes source 50 a dma trigger when set, an ordinary interrupt when clear.
// - bit 28 makes source 51 a dma trigger when set, an ordinary interrupt when clear.
// - with the trigger bit clear the 3-bit field is the cpu level, 000 disabled, 1 to 7 levels.
// - with the trigger bit set the same 3-bit field selects the dma channel instead.
// - channel selector codes map straight onto dma channels 0 to 7.
// - source 48 active state field bits 6:5 uses code 01, high level active.
// - sources 49 to 51 active state fields use code 11, rising edge detection.
// - bits 3,7,11,15,19,23,27,31 read as zero and all fields reset to zero.
package imc_pkg;

  localparam int          IMC_NSRC         = 4;
  localparam int          IMC_FIRST_SRC    = 48;
  localparam logic [31:0] IMC_OFS_MODE     = 32'hFFFFE030;
  localparam logic [31:0] IMC_OFS_STATUS   = 32'hFFFFE0F0;
  localparam logic [31:0] IMC_OFS_MASK     = 32'hFFFFE0F4;
  localparam logic [31:0] IMC_MODE_RESET   = 32'h00000000;
  localparam logic [31:0] IMC_MODE_WMASK   = 32'h77777777;
  localparam logic [3:0]  IMC_IRQ_RESET    = 4'h0;
  localparam int          IMC_LANE_W       = 8;
  localparam int          IMC_LVL_LSB      = 0;
  localparam int          IMC_DMA_BIT      = 4;
  localparam int          IMC_ACT_LSB      = 5;
  localparam logic [1:0]  IMC_ACT_HIGH     = 2'h1;
  localparam logic [1:0]  IMC_ACT_RISE     = 2'h3;
  localparam logic [2:0]  IMC_LVL_OFF      = 3'h0;

  typedef struct packed {
    logic [1:0] act;
    logic       dma;
    logic [2:0] lvl;
  } imc_lane_s;

  typedef struct packed {
    logic       req;
    logic [2:0] level;
  } imc_cpu_req_s;

  typedef struct packed {
    logic       req;
    logic [2:0] chan;
  } imc_dma_req_s;

endpackage

// ===== verilog/imc_src_lane.sv
/*
  one interrupt source lane: synchronise the request pin, detect its
  active state and route it to the cpu or to a dma channel.
  assumes the lane configuration is stable from the register file.
*/
`timescale 1ns/1ps
module imc_src_lane
  import imc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         src_pin,
  input  wire imc_lane_s    cfg,
  output imc_cpu_req_s      cpu_req,
  output imc_dma_req_s      dma_req,
  output logic              event_pulse
);

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] sync_reg;
  logic       lvl_reg;
  logic       hit;
  logic       rise;
  logic       high;
  logic       high_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_reg <= 3'h0;
      lvl_reg  <= 1'b0;
      high_d   <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], src_pin};
      high_d   <= lvl_reg;
      if (sync_reg[2] == sync_reg[1])
        lvl_reg <= sync_reg[1];
    end
  end

  // filtered level only changes once stages two and three agree
  assign high = lvl_reg;
  assign rise = (sync_reg[2] == sync_reg[1]) && sync_reg[1] && !lvl_reg;
  assign hit  = (cfg.act == IMC_ACT_HIGH) ? high :
                (cfg.act == IMC_ACT_RISE) ? rise : 1'b0;

  // level 000 disables the cpu path only, never the dma path
  assign cpu_req.req   = hit && !cfg.dma && (cfg.lvl != IMC_LVL_OFF);
  assign cpu_req.level = cfg.dma ? IMC_LVL_OFF : cfg.lvl;
  assign dma_req.req   = hit && cfg.dma;
  assign dma_req.chan  = cfg.lvl;
  // level mode flags status only on the cycle the level comes up
  assign event_pulse   = hit && (cfg.act == IMC_ACT_RISE ? 1'b1 : !high_d);

  AST_DMA_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
    !(cpu_req.req && dma_req.req))
    else $error("cpu and dma request together");

endmodule

// ===== verilog/imc_top.sv
/*
  interrupt mode control register for sources 48 to 51 with apb slave,
  per-lane request routing, sticky event status, mask and irq output.
  assumes a single apb master on pclk; source pins are asynchronous.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module imc_top
  import imc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [IMC_NSRC-1:0]   src_pin,
  output logic      [IMC_NSRC-1:0]   cpu_req,
  output logic      [IMC_NSRC*3-1:0] cpu_level,
  output logic      [IMC_NSRC-1:0]   dma_req,
  output logic      [IMC_NSRC*3-1:0] dma_chan,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]          mode_reg;
  logic [31:0]          mode_next;
  logic [IMC_NSRC-1:0]  status_reg;
  logic [IMC_NSRC-1:0]  status_next;
  logic [IMC_NSRC-1:0]  mask_reg;
  logic [IMC_NSRC-1:0]  mask_next;
  logic [31:0]          prdata_reg;
  logic [IMC_NSRC-1:0]  ev;
  logic [31:0]          bmask;
  logic [31:0]          rd_mux;
  logic                 wr_en;
  logic                 rd_en;
  logic                 sel_mode;
  logic                 sel_stat;
  logic                 sel_mask;
  logic                 sel_any;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign sel_mode = (paddr == IMC_OFS_MODE);
  assign sel_stat = (paddr == IMC_OFS_STATUS);
  assign sel_mask = (paddr == IMC_OFS_MASK);
  assign sel_any  = sel_mode || sel_stat || sel_mask;
  assign bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !sel_any;
  assign prdata  = prdata_reg;

  // unused bits never stored, so they read zero
  assign mode_next = (wr_en && sel_mode) ?
    ((mode_reg & ~bmask) | (pwdata & bmask & IMC_MODE_WMASK)) : mode_reg;
  // set wins over a write-one clear in the same cycle
  assign status_next = (wr_en && sel_stat && pstrb[0]) ?
    ((status_reg & ~pwdata[IMC_NSRC-1:0]) | ev) : (status_reg | ev);
  assign mask_next = (wr_en && sel_mask && pstrb[0]) ? pwdata[IMC_NSRC-1:0] : mask_reg;

  assign rd_mux = sel_mode ? mode_reg :
                  sel_stat ? {28'h0000000, status_reg} :
                  sel_mask ? {28'h0000000, mask_reg} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg   <= IMC_MODE_RESET;
      status_reg <= IMC_IRQ_RESET;
      mask_reg   <= IMC_IRQ_RESET;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      mode_reg   <= mode_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      prdata_reg <= rd_en ? rd_mux : prdata_reg;
    end
  end

  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // one lane per byte of the mode register
  genvar g;
  generate
    for (g = 0; g < IMC_NSRC; g++)
    begin : g_lane
      imc_lane_s    cfg;
      imc_cpu_req_s c_req;
      imc_dma_req_s d_req;
      assign cfg.lvl = mode_reg[g*IMC_LANE_W+IMC_LVL_LSB +: 3];
      assign cfg.dma = mode_reg[g*IMC_LANE_W+IMC_DMA_BIT];
      assign cfg.act = mode_reg[g*IMC_LANE_W+IMC_ACT_LSB +: 2];
      imc_src_lane u_lane
      (
        .pclk        (pclk),
        .presetn     (presetn),
        .src_pin     (src_pin[g]),
        .cfg         (cfg),
        .cpu_req     (c_req),
        .dma_req     (d_req),
        .event_pulse (ev[g])
      );
      assign cpu_req[g]         = c_req.req;
      assign cpu_level[g*3 +: 3] = c_req.level;
      assign dma_req[g]         = d_req.req;
      assign dma_chan[g*3 +: 3] = d_req.chan;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg & ~IMC_MODE_WMASK) == 32'h00000000)
    else $error("reserved mode bit set");
  AST_DMA48: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req[0] |-> mode_reg[4])
    else $error("src48 dma without trigger bit");
  AST_DMA49: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req[1] |-> mode_reg[12])
    else $error("src49 dma without trigger bit");
  AST_DMA50: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req[2] |-> mode_reg[20])
    else $error("src50 dma without trigger bit");
  AST_DMA51: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req[3] |-> mode_reg[28])
    else $error("src51 dma without trigger bit");
  AST_LVL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_req[0] |-> (cpu_level[2:0] != 3'h0) && !mode_reg[4])
    else $error("disabled level raised cpu request");
  AST_CHAN: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req[0] |-> dma_chan[2:0] == mode_reg[2:0])
    else $error("dma channel not taken from level field");
  AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_mode && (pstrb == 4'hF)) |=> mode_reg == ($past(pwdata) & IMC_MODE_WMASK))
    else $error("mode write not stored");
  AST_HIGH48: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg[6:5] == 2'h1 && !mode_reg[4] && mode_reg[2:0] != 3'h0
      && g_lane[0].u_lane.lvl_reg) |-> cpu_req[0])
    else $error("high level not requested");
  AST_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg[14:13] == 2'h3 && dma_req[1]) |=> !dma_req[1])
    else $error("rising edge request longer than one cycle");

endmodule

// ===== sim/imc_dma_model.sv
/*
  dma controller stand-in: counts request rises per selected channel.
  assumes imc_top drives dma_req and dma_chan on pclk.
*/
`timescale 1ns/1ps
module imc_dma_model
  import imc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [IMC_NSRC-1:0]   dma_req,
  input  wire logic [IMC_NSRC*3-1:0] dma_chan,
  output logic      [63:0]           hits
);
  logic [IMC_NSRC-1:0] req_d;
  // two lanes on one channel in one cycle count once: tests keep channels apart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_d <= '0;
      hits  <= '0;
    end
    else
    begin
      req_d <= dma_req;
      for (int i = 0; i < IMC_NSRC; i++)
        if (dma_req[i] && !req_d[i])
          hits[dma_chan[i*3 +: 3]*8 +: 8] <= hits[dma_chan[i*3 +: 3]*8 +: 8] + 8'h01;
    end
  end
endmodule

// ===== sim/interrupt_mode_control_48_51_bench.sv
/*
  self-checking bench: apb master tasks, source pins, dma stand-in.
  assumes zero-wait apb slave and 3-flop pin filtering in imc_top.
*/
`timescale 1ns/1ps
module interrupt_mode_control_48_51_bench;
  import imc_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h00000000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  src_pin = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err;
  logic [3:0]  cpu_req, dma_req;
  logic [11:0] cpu_level, dma_chan;
  logic [63:0] hits;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cnt[4];

  imc_top u_imc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_pin(src_pin), .cpu_req(cpu_req),
    .cpu_level(cpu_level), .dma_req(dma_req), .dma_chan(dma_chan), .irq(irq));
  imc_dma_model u_imc_dma_model (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_chan(dma_chan), .hits(hits));

  always #10 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 10);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 10)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, IMC_OFS_MODE, 0);
    chk("mode reset", 32'h00000000, rd);
    apb(1, IMC_OFS_MODE, 32'hFFFFFFFF);
    apb(0, IMC_OFS_MODE, 0);
    chk("mode unused bits", 32'h77777777, rd);
    apb(0, 32'hFFFFE0F8, 0);
    chk("unmapped", 32'h00000001, {rd[30:0], err});
  endtask

  task automatic t_level;
    for (int l = 0; l < 8; l++)
    begin
      apb(1, IMC_OFS_MODE, 32'h00000020 | l);
      src_pin[0] <= 1'b1;
      cy(6);
      chk("cpu lane0", {l != 0, 3'(l)}, {cpu_req[0], cpu_level[2:0]});
      src_pin[0] <= 1'b0;
      cy(6);
    end
  endtask

  task automatic t_edge;
    apb(1, IMC_OFS_MODE, 32'h63626100);
    cnt = '{0, 0, 0, 0};
    src_pin <= 4'hE;
    repeat (10)
    begin
      @(negedge pclk);
      for (int i = 1; i < 4; i++)
        cnt[i] += cpu_req[i];
    end
    for (int i = 1; i < 4; i++)
      chk("edge pulses", 1, cnt[i]);
    src_pin <= 4'h0;
    cy(6);
  endtask

  task automatic t_dma;
    logic [31:0] m;
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 4; i++)
        m[i*8 +: 8] = (i == 0 ? 8'h30 : 8'h70) | 8'(i + 4*p);
      apb(1, IMC_OFS_MODE, m);
      src_pin <= 4'hF;
      cy(6);
      chk("cpu off in dma", 0, {cpu_req[0], cpu_level[2:0]});
      cy(4);
      for (int i = 0; i < 4; i++)
        chk("dma hits", 1, hits[(i + 4*p)*8 +: 8]);
      src_pin <= 4'h0;
      cy(6);
    end
  endtask

  task automatic t_irq;
    apb(1, IMC_OFS_MASK, 0);
    apb(1, IMC_OFS_STATUS, 32'h0000000F);
    apb(1, IMC_OFS_MODE, 32'h00000021);
    src_pin <= 4'h1;
    cy(8);
    apb(0, IMC_OFS_STATUS, 0);
    chk("status masked irq", 32'h00000002, {rd[30:0], irq});
    apb(1, IMC_OFS_MASK, 1);
    cy(2);
    chk("irq unmasked", 1, irq);
    src_pin <= 4'h0;
    apb(1, IMC_OFS_STATUS, 1);
    cy(2);
    chk("irq cleared", 0, irq);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cy(20);
    presetn <= 1'b1;
    t_regs();
    t_level();
    t_edge();
    t_dma();
    t_irq();
    finish_test();
  end
endmodule
